// ===== hdl/apo_top.sv
// converter parallel output port: sampling, latency, coding and status
`include "apo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module apo_top (
  input wire logic clk, // system clock, 125 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic conv_clk, // convert clock from the capture side
  input wire logic [`APO_WIDTH-1:0] analog_code, // quantizer result, offset binary
  input wire logic twos_complement_select, // high: two's complement words
  input wire logic output_enable_n, // low: drive the data lines
  input wire logic power_down_in, // high: power down
  input wire logic [1:0] range_select_a, // first range strap, apo_strap_t
  input wire logic range_select_b, // second range strap, high at supply
  input wire logic ref_pin_at_supply, // reference pin tied to supply
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after the strobe
  output logic [1:`APO_WIDTH] sample_lines, // parallel word, line 1 is msb
  output logic sample_lines_oe, // high while the lines are driven
  output logic sample_valid, // one-cycle strobe per new word
  output logic [2:0] full_scale_code // decoded range, apo_fs_t
);
  logic conv_q;
  logic conv_rise;
  logic advance;
  logic [`APO_WIDTH-1:0] pipe_data;
  logic pipe_valid;
  apo_pkg::apo_state_t state;
  logic [`APO_FILL_BITS-1:0] fill_cnt;
  logic [15:0] sample_count;
  logic count_en;
  logic [7:0] gap_cnt;
  logic edge_seen;
  logic rate_slow;
  logic rate_fast;
  logic slow_evt;
  logic fast_evt;
  logic clr_count;
  logic clr_err;
  logic ctrl_wr;
  apo_pkg::apo_fs_t next_fs;

  // convert edge detect; the pin is already synchronous to clk
  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= conv_clk;
    end
  end

  // only the rising edge counts, the falling edge starts nothing
  assign conv_rise = conv_clk && !conv_q;
  assign advance = conv_rise && !power_down_in;

  apo_latency_pipe u_pipe (
    .clk(clk),
    .nrst(nrst),
    .flush(power_down_in),
    .advance(advance),
    .din(analog_code),
    .dout(pipe_data),
    .dout_valid(pipe_valid)
  );

  apo_out_format u_fmt (
    .clk(clk),
    .nrst(nrst),
    .flush(power_down_in),
    .load(advance),
    .twos(twos_complement_select),
    .oe_n(output_enable_n),
    .din(pipe_data),
    .din_valid(pipe_valid),
    .lines(sample_lines),
    .lines_oe(sample_lines_oe),
    .valid(sample_valid)
  );

  // run state: off in power-down, filling until the pipe delivers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= apo_pkg::apo_st_off;
      fill_cnt <= '0;
    end else if (power_down_in) begin
      state <= apo_pkg::apo_st_off;
      fill_cnt <= '0;
    end else begin
      case (state)
        apo_pkg::apo_st_off: begin
          state <= apo_pkg::apo_st_fill;
          fill_cnt <= '0;
        end
        apo_pkg::apo_st_fill: begin
          // words before the pipe fills carry no sample
          if (advance) begin
            if (fill_cnt == `APO_FILL_BITS'(`APO_LATENCY - 1)) begin
              state <= apo_pkg::apo_st_run;
            end
            fill_cnt <= fill_cnt + `APO_FILL_BITS'(1);
          end
        end
        apo_pkg::apo_st_run: begin
          state <= apo_pkg::apo_st_run;
        end
        default: begin
          state <= apo_pkg::apo_st_off;
        end
      endcase
    end
  end

  // full-scale decode from the straps
  always_comb begin
    next_fs = apo_pkg::apo_fs_bad;
    if (ref_pin_at_supply) begin
      next_fs = apo_pkg::apo_fs_ext;
    end else begin
      case (apo_pkg::apo_strap_t'(range_select_a))
        apo_pkg::apo_strap_gnd: begin
          next_fs = range_select_b ? apo_pkg::apo_fs_3vpp : apo_pkg::apo_fs_4vpp;
        end
        apo_pkg::apo_strap_ref: begin
          next_fs = range_select_b ? apo_pkg::apo_fs_bad : apo_pkg::apo_fs_2vpp;
        end
        default: begin
          next_fs = apo_pkg::apo_fs_bad;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      full_scale_code <= apo_pkg::apo_fs_4vpp;
    end else begin
      full_scale_code <= next_fs;
    end
  end

  // convert-rate monitor in clk cycles
  assign fast_evt = conv_rise && edge_seen && gap_cnt < 8'(`APO_CONV_MIN_CYC - 1);
  assign slow_evt = edge_seen && gap_cnt == 8'(`APO_CONV_MAX_CYC);

  always_ff @(posedge clk) begin
    if (!nrst || power_down_in) begin
      gap_cnt <= 8'h00;
      edge_seen <= 1'b0;
    end else if (conv_rise) begin
      gap_cnt <= 8'h00;
      edge_seen <= 1'b1;
    end else if (gap_cnt != 8'(`APO_CONV_MAX_CYC)) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  // sticky rate flags; a new event wins over a clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_slow <= 1'b0;
      rate_fast <= 1'b0;
    end else begin
      rate_slow <= slow_evt || (rate_slow && !clr_err);
      rate_fast <= fast_evt || (rate_fast && !clr_err);
    end
  end

  // register writes
  assign ctrl_wr = reg_wr && reg_addr == `APO_ADDR_CTRL;
  assign clr_count = ctrl_wr && reg_wdata[`APO_CTRL_CLR_COUNT_BIT];
  assign clr_err = ctrl_wr && reg_wdata[`APO_CTRL_CLR_ERR_BIT];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_en <= `APO_CTRL_COUNT_EN_RESET;
    end else if (ctrl_wr) begin
      count_en <= reg_wdata[`APO_CTRL_COUNT_EN_BIT];
    end
  end

  // delivered word counter; a word in the clear cycle still counts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sample_count <= `APO_COUNT_RESET;
    end else if (clr_count) begin
      sample_count <= (sample_valid && count_en) ? 16'h0001 : 16'h0000;
    end else if (sample_valid && count_en) begin
      sample_count <= sample_count + 16'h0001;
    end
  end

  // register reads; data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst || !reg_rd) begin
      reg_rdata <= `APO_RDATA_RESET;
    end else begin
      case (reg_addr)
        `APO_ADDR_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[`APO_STATUS_PD_BIT] <= state == apo_pkg::apo_st_off;
          reg_rdata[`APO_STATUS_FS_LSB +: 3] <= full_scale_code;
          reg_rdata[`APO_STATUS_FILL_LSB +: `APO_FILL_BITS] <= fill_cnt;
          reg_rdata[`APO_STATUS_SLOW_BIT] <= rate_slow;
          reg_rdata[`APO_STATUS_FAST_BIT] <= rate_fast;
          reg_rdata[`APO_STATUS_RUN_BIT] <= state == apo_pkg::apo_st_run;
        end
        `APO_ADDR_COUNT: begin
          reg_rdata <= {16'h0000, sample_count};
        end
        `APO_ADDR_CTRL: begin
          reg_rdata <= '0;
          reg_rdata[`APO_CTRL_COUNT_EN_BIT] <= count_en;
        end
        default: begin
          reg_rdata <= `APO_RDATA_RESET;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_fall_idle;
    !conv_clk && conv_q |-> !advance;
  endproperty
  a_fall_idle: assert property (p_fall_idle) else $error("falling edge started a sample");

  property p_rise_starts;
    conv_clk && !conv_q && !power_down_in |-> advance ##1 conv_q;
  endproperty
  a_rise_starts: assert property (p_rise_starts) else $error("rising edge missed");

  property p_pd_quiet;
    power_down_in |=> !sample_valid && state == apo_pkg::apo_st_off;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("activity during power-down");

  property p_valid_cause;
    sample_valid |-> $past(advance) && state != apo_pkg::apo_st_off;
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("strobe without a convert edge");

  property p_no_early_word;
    state == apo_pkg::apo_st_fill && advance |=> !sample_valid || state == apo_pkg::apo_st_run;
  endproperty
  a_no_early_word: assert property (p_no_early_word) else $error("word before pipe filled");

  property p_ext_ref;
    ref_pin_at_supply |=> full_scale_code == apo_pkg::apo_fs_ext;
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("external reference not decoded");

  property p_rd_once;
    reg_rd ##1 !reg_rd |=> reg_rdata == `APO_RDATA_RESET;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data stood too long");

  c_word: cover property (sample_valid);
  c_wake: cover property (power_down_in ##1 !power_down_in [*8]);
  c_run: cover property (state == apo_pkg::apo_st_run && sample_valid);
  c_fast: cover property (fast_evt);
endmodule : apo_top
`default_nettype wire

// ===== common/apo_defines.svh
// constants for the converter parallel output port
`ifndef APO_DEFINES_SVH
`define APO_DEFINES_SVH

`define APO_WIDTH 14
`define APO_LATENCY 10
`define APO_FILL_BITS 4

`define APO_CLK_PERIOD_NS 8
`define APO_CONV_MIN_PERIOD_NS 25
`define APO_CONV_MAX_PERIOD_NS 1000
`define APO_CONV_MIN_CYC \
  (((`APO_CONV_MIN_PERIOD_NS) + (`APO_CLK_PERIOD_NS) - 1) / (`APO_CLK_PERIOD_NS))
`define APO_CONV_MAX_CYC ((`APO_CONV_MAX_PERIOD_NS) / (`APO_CLK_PERIOD_NS))

`define APO_ADDR_STATUS 4'h0
`define APO_ADDR_COUNT 4'h4
`define APO_ADDR_CTRL 4'h8

`define APO_STATUS_PD_BIT 0
`define APO_STATUS_FS_LSB 1
`define APO_STATUS_FILL_LSB 4
`define APO_STATUS_SLOW_BIT 8
`define APO_STATUS_FAST_BIT 9
`define APO_STATUS_RUN_BIT 10

`define APO_CTRL_CLR_COUNT_BIT 0
`define APO_CTRL_CLR_ERR_BIT 1
`define APO_CTRL_COUNT_EN_BIT 2
`define APO_CTRL_COUNT_EN_RESET 1'b1
`define APO_COUNT_RESET 16'h0000
`define APO_RDATA_RESET 32'h0000_0000

`endif

// ===== common/apo_pkg.sv
// types shared by the converter parallel output port
`default_nettype none
package apo_pkg;
  typedef enum logic [2:0] {
    apo_fs_4vpp = 3'b000,
    apo_fs_3vpp = 3'b001,
    apo_fs_2vpp = 3'b010,
    apo_fs_ext = 3'b011,
    apo_fs_bad = 3'b100
  } apo_fs_t;

  typedef enum logic [1:0] {
    apo_strap_gnd = 2'b00,
    apo_strap_supply = 2'b01,
    apo_strap_ref = 2'b10
  } apo_strap_t;

  typedef enum logic [1:0] {
    apo_st_off = 2'b00,
    apo_st_fill = 2'b01,
    apo_st_run = 2'b10
  } apo_state_t;
endpackage : apo_pkg
`default_nettype wire

// ===== hdl/apo_latency_pipe.sv
// conversion latency pipeline, one stage per convert edge
`include "apo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module apo_latency_pipe (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic flush, // drop every sample in flight
  input wire logic advance, // convert edge seen
  input wire logic [`APO_WIDTH-1:0] din, // quantizer result, offset binary
  output logic [`APO_WIDTH-1:0] dout, // oldest stage
  output logic dout_valid // oldest stage holds a real sample
);
  logic [`APO_WIDTH-1:0] st_data [0:`APO_LATENCY-1];
  logic [`APO_LATENCY-1:0] st_valid;

  genvar i;
  for (i = 0; i < `APO_LATENCY; i++) begin : g_stage
    // stage zero points at itself so the select never leaves the range
    localparam int prev_idx = (i == 0) ? 0 : i - 1;
    always_ff @(posedge clk) begin
      if (!nrst || flush) begin
        st_valid[i] <= 1'b0;
        st_data[i] <= '0;
      end else if (advance) begin
        if (i == 0) begin
          st_valid[i] <= 1'b1;
          st_data[i] <= din;
        end else begin
          st_valid[i] <= st_valid[prev_idx];
          st_data[i] <= st_data[prev_idx];
        end
      end
    end
  end

  assign dout = st_data[`APO_LATENCY-1];
  assign dout_valid = st_valid[`APO_LATENCY-1];

  // tracker: follows one sample through the stages
  logic [`APO_WIDTH-1:0] trk_data;
  logic [3:0] trk_cnt;
  logic trk_busy;
  always_ff @(posedge clk) begin
    if (!nrst || flush) begin
      trk_busy <= 1'b0;
      trk_cnt <= 4'h0;
      trk_data <= '0;
    end else if (trk_busy && trk_cnt == 4'(`APO_LATENCY - 1)) begin
      trk_busy <= 1'b0;
    end else if (advance) begin
      if (!trk_busy) begin
        trk_busy <= 1'b1;
        trk_cnt <= 4'h0;
        trk_data <= din;
      end else begin
        trk_cnt <= trk_cnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_latency;
    trk_busy && trk_cnt == 4'(`APO_LATENCY - 1) |-> dout_valid && dout == trk_data;
  endproperty
  a_latency: assert property (p_latency) else $error("sample not at pipe end on time");

  property p_flush_empty;
    flush |=> !dout_valid;
  endproperty
  a_flush_empty: assert property (p_flush_empty) else $error("flush left a valid sample");
endmodule : apo_latency_pipe
`default_nettype wire

// ===== hdl/apo_out_format.sv
// output coding, line order, enable and valid strobe
`include "apo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module apo_out_format (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic flush, // power-down: clear word and strobe
  input wire logic load, // convert edge: take the oldest stage
  input wire logic twos, // two's complement coding
  input wire logic oe_n, // output enable, active low
  input wire logic [`APO_WIDTH-1:0] din, // oldest stage, offset binary
  input wire logic din_valid, // oldest stage is real
  output logic [1:`APO_WIDTH] lines, // line 1 carries the msb
  output logic lines_oe, // high while lines are driven
  output logic valid // one-cycle strobe on each new word
);
  logic [`APO_WIDTH-1:0] coded;
  logic [`APO_WIDTH-1:0] seen;
  logic take;

  assign take = load && din_valid && !flush;
  // two's complement differs from offset binary only in the msb
  assign coded = twos ? {~din[`APO_WIDTH-1], din[`APO_WIDTH-2:0]} : din;

  genvar i;
  for (i = 0; i < `APO_WIDTH; i++) begin : g_line
    always_ff @(posedge clk) begin
      if (!nrst || flush) begin
        lines[i+1] <= 1'b0;
      end else if (take) begin
        lines[i+1] <= coded[`APO_WIDTH-1-i];
      end
    end
    assign seen[`APO_WIDTH-1-i] = lines[i+1];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lines_oe <= 1'b0;
    end else begin
      lines_oe <= !oe_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      valid <= 1'b0;
    end else begin
      valid <= take;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_offset;
    take && !twos |=> seen == $past(din);
  endproperty
  a_offset: assert property (p_offset) else $error("offset binary word wrong");

  property p_twos;
    take && twos |=> seen == {~$past(din[`APO_WIDTH-1]), $past(din[`APO_WIDTH-2:0])};
  endproperty
  a_twos: assert property (p_twos) else $error("two's complement word wrong");

  property p_oe;
    oe_n |=> !lines_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("lines driven while disabled");

  property p_oe_on;
    !oe_n ##1 !oe_n |=> lines_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("lines not driven while enabled");

  property p_msb_line;
    take && !twos |=> lines[1] == $past(din[`APO_WIDTH-1]);
  endproperty
  a_msb_line: assert property (p_msb_line) else $error("first line is not the msb");

  property p_lsb_line;
    take |=> lines[`APO_WIDTH] == $past(din[0]);
  endproperty
  a_lsb_line: assert property (p_lsb_line) else $error("last line is not the lsb");

  property p_hold;
    valid ##1 !take |=> $stable(seen) || $past(flush);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed without a new sample");

  c_twos: cover property (take && twos);
endmodule : apo_out_format
`default_nettype wire

// ===== tb/apo_capture_model.sv
// capture side model: convert clock source, analog codes and word checker
`include "apo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module apo_capture_model (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic run, // let the convert clock toggle
  input wire logic clear, // forget counts after a flush
  input wire logic [7:0] half, // half period in clk cycles
  input wire logic twos, // coding expected on the lines
  input wire logic [1:`APO_WIDTH] lines, // parallel word
  input wire logic valid, // word strobe
  output logic conv_clk, // convert clock
  output logic [`APO_WIDTH-1:0] code, // analog code of the latest sample
  output logic [7:0] rises, // convert edges since clear
  output logic [7:0] words, // words latched since clear
  output logic [7:0] bad // words with wrong value or latency
);
  logic [7:0] cnt;
  logic rise;
  logic [`APO_WIDTH-1:0] codes [0:255];
  logic [`APO_WIDTH-1:0] exp_word;
  assign rise = run && (cnt == half - 8'h01) && !conv_clk;
  assign exp_word = twos ? (codes[words + 8'h01] ^ 14'h2000) : codes[words + 8'h01];
  // clock stands low outside runs
  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      conv_clk <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      conv_clk <= !conv_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      rises <= 8'h00;
      code <= 14'h0123;
    end else if (rise) begin
      rises <= rises + 8'h01;
      code <= code + 14'h0A35;
      codes[rises + 8'h01] <= code + 14'h0A35;
    end
  end
  // latch only qualified words; sample n is due at edge n+10
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      words <= 8'h00;
      bad <= 8'h00;
    end else if (valid) begin
      words <= words + 8'h01;
      if (lines !== exp_word || rises !== words + 8'h0B) begin
        bad <= bad + 8'h01;
      end
    end
  end
endmodule : apo_capture_model
`default_nettype wire

// ===== tb/apo_top_tb.sv
// testbench for the converter parallel output port
`include "apo_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module apo_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic twos = 1'b0;
  logic oe_n = 1'b0;
  logic pd = 1'b0;
  logic [1:0] ra = 2'h0;
  logic rb = 1'b0;
  logic rf = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic clear = 1'b0;
  logic [7:0] half = 8'h04;
  logic [31:0] reg_rdata;
  logic [1:`APO_WIDTH] lines;
  logic oe;
  logic valid;
  logic [2:0] fs;
  logic conv_clk;
  logic [`APO_WIDTH-1:0] code;
  logic [7:0] rises;
  logic [7:0] words;
  logic [7:0] bad;
  wire [1:`APO_WIDTH] data_bus;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] rd;
  assign data_bus = oe ? lines : 14'bz;
  always #4 clk = !clk;
  apo_top dut (.clk(clk), .nrst(nrst), .conv_clk(conv_clk), .analog_code(code),
    .twos_complement_select(twos), .output_enable_n(oe_n), .power_down_in(pd),
    .range_select_a(ra), .range_select_b(rb), .ref_pin_at_supply(rf),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_lines(lines), .sample_lines_oe(oe),
    .sample_valid(valid), .full_scale_code(fs));
  apo_capture_model partner (.clk(clk), .nrst(nrst), .run(run), .clear(clear),
    .half(half), .twos(twos), .lines(lines), .valid(valid), .conv_clk(conv_clk),
    .code(code), .rises(rises), .words(words), .bad(bad));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // run the convert clock for n rising edges, then let the last word land
  task automatic conv(input int n, input logic [7:0] h);
    int i;
    @(posedge clk);
    half <= h;
    run <= 1'b1;
    for (i = 0; i < 5000 && rises !== n[7:0]; i++) @(posedge clk);
    run <= 1'b0;
    check("convert edges", {24'h0, rises}, n);
    cyc(6);
  endtask : conv
  task automatic flush;
    @(posedge clk);
    pd <= 1'b1;
    cyc(3);
    pd <= 1'b0;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
  endtask : flush
  task automatic test_stream(input logic t);
    twos <= t;
    flush();
    conv(30, 8'h04);
    check("words", {24'h0, words}, 32'd20);
    check("bad words", {24'h0, bad}, 32'd0);
    reg_read(`APO_ADDR_STATUS, rd);
    check("status running", {31'h0, rd[`APO_STATUS_RUN_BIT]}, 32'd1);
    check("status fill", {28'h0, rd[`APO_STATUS_FILL_LSB +: 4]}, 32'(`APO_LATENCY));
    $display("test_stream done, twos %0b", t);
  endtask : test_stream
  task automatic test_power_down;
    @(posedge clk);
    pd <= 1'b1;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    conv(20, 8'h05);
    check("words in power-down", {24'h0, words}, 32'd0);
    reg_read(`APO_ADDR_STATUS, rd);
    check("status powered-down", {31'h0, rd[`APO_STATUS_PD_BIT]}, 32'd1);
    pd <= 1'b0;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    conv(14, 8'h05);
    check("words after wake", {24'h0, words}, 32'd4);
    check("bad after wake", {24'h0, bad}, 32'd0);
    $display("test_power_down done");
  endtask : test_power_down
  task automatic test_oe;
    oe_n <= 1'b1;
    cyc(3);
    check("lines floating", {18'h0, data_bus}, {18'h0, 14'bz});
    oe_n <= 1'b0;
    cyc(3);
    check("lines driven", {31'h0, oe}, 32'd1);
    check("lines value", {18'h0, data_bus}, {18'h0, lines});
    $display("test_oe done");
  endtask : test_oe
  task automatic test_range;
    logic [1:0] ta [5] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h2};
    logic tb_ [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic tr [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [2:0] te [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    for (int i = 0; i < 5; i++) begin
      ra <= ta[i];
      rb <= tb_[i];
      rf <= tr[i];
      cyc(3);
      check("full scale", {29'h0, fs}, {29'h0, te[i]});
      reg_read(`APO_ADDR_STATUS, rd);
      check("status range", {29'h0, rd[3:1]}, {29'h0, te[i]});
    end
    ra <= 2'h0;
    rb <= 1'b0;
    rf <= 1'b0;
    $display("test_range done");
  endtask : test_range
  task automatic test_regs;
    reg_write(`APO_ADDR_CTRL, 32'h0000_0005);
    reg_read(`APO_ADDR_COUNT, rd);
    check("count cleared", rd, 32'h0000_0000);
    flush();
    conv(15, 8'h03);
    reg_read(`APO_ADDR_COUNT, rd);
    check("count words", rd, 32'h0000_0005);
    reg_read(`APO_ADDR_CTRL, rd);
    check("count enable", {31'h0, rd[`APO_CTRL_COUNT_EN_BIT]}, 32'd1);
    reg_read(4'hC, rd);
    check("unmapped", rd, 32'h0000_0000);
    reg_write(`APO_ADDR_CTRL, 32'h0000_0000);
    flush();
    conv(12, 8'h03);
    reg_read(`APO_ADDR_COUNT, rd);
    check("count held", rd, 32'h0000_0005);
    reg_write(`APO_ADDR_CTRL, 32'h0000_0004);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_rate;
    reg_write(`APO_ADDR_CTRL, 32'h0000_0006);
    flush();
    conv(6, 8'h01);
    reg_read(`APO_ADDR_STATUS, rd);
    check("fast flag", {31'h0, rd[`APO_STATUS_FAST_BIT]}, 32'd1);
    reg_write(`APO_ADDR_CTRL, 32'h0000_0006);
    reg_read(`APO_ADDR_STATUS, rd);
    check("fast cleared", {31'h0, rd[`APO_STATUS_FAST_BIT]}, 32'd0);
    flush();
    conv(3, 8'h46);
    reg_read(`APO_ADDR_STATUS, rd);
    check("slow flag", {31'h0, rd[`APO_STATUS_SLOW_BIT]}, 32'd1);
    $display("test_rate done");
  endtask : test_rate
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    cyc(10);
    nrst <= 1'b1;
    #1 check("valid at reset", {31'h0, valid}, 32'd0);
    test_range();
    test_stream(1'b0);
    test_stream(1'b1);
    test_power_down();
    test_oe();
    test_regs();
    test_rate();
    end_sim();
  end
  initial begin
    cyc(20000);
    mismatches++;
    end_sim();
  end
endmodule : apo_top_tb
`default_nettype wire
